// >>> logic/card_if_regs.vh
// Constants for the smart card interface control block
`ifndef CARD_IF_REGS_VH
`define CARD_IF_REGS_VH
`define CLK_FREQ_HZ 40000000
`define DEBOUNCE_MS 8
`define DEBOUNCE_CYCLES ((`CLK_FREQ_HZ / 1000) * `DEBOUNCE_MS)
`define DIV_SEL_BY1 2'h0
`define DIV_SEL_BY2 2'h1
`define DIV_SEL_BY4 2'h2
`define DIV_SEL_BY8 2'h3
`define DEACT_STEP_CYCLES 8'h04
`endif

// >>> logic/smart_card_interface_control.v
// Smart card interface control: clock divider, supply, presence, sequencing, line relay
`timescale 1ns/1ps
`include "card_if_regs.vh"

// Behaviour
// - Divide host clock by 1, 2, 4 or 8 from two select pins.
// - Card clock output carries the divided host clock.
// - Card reset follows host reset request while the card is active.
// - Card supply selects 5 V when select high, 3 V when low.
// - Two presence inputs: one active low, one active high.
// - Card counts present only after input holds asserted about 8 ms.
// - Overload, overheat, removal or supply drop trigger automatic deactivation.
// - Interrupt reports card presence and faults.
// - Serial and two aux lines relayed both ways; host side idles high, card side held low.
// - Activation starts on command falling edge only with card present.
// - Interrupt output driven low when active, idles high.
module smart_card_interface_control #(
    parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // Host control pins
    input wire host_clock_in,
    input wire divider_select_a_in,
    input wire divider_select_b_in,
    input wire card_supply_select_in,
    input wire host_reset_request_in,
    input wire activation_command_n_in,
    output reg interrupt_n_out,
    // Card presence and fault sensing
    input wire card_presence_low_in,
    input wire card_presence_high_in,
    input wire supply_overload_in,
    input wire over_temperature_in,
    input wire supply_dropout_in,
    // Card power and control
    output reg card_supply_enable_out,
    output reg card_supply_5v_out,
    output reg card_clock_out,
    output reg card_reset_out,
    output wire card_active_out,
    // Host side lines: serial, aux a, aux b
    input wire [2:0] host_line_in,
    output wire [2:0] host_line_out,
    output wire [2:0] host_line_oe_out,
    // Card side lines: serial, aux a, aux b
    input wire [2:0] card_line_in,
    output wire [2:0] card_line_out,
    output wire [2:0] card_line_oe_out
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ACTIVE = 5'h02;
    localparam [4:0] ST_D_RST = 5'h04;
    localparam [4:0] ST_D_CLK = 5'h08;
    localparam [4:0] ST_D_IO = 5'h10;

    // Two-flop synchronisers for all external levels except faults, supply select and reset
    reg [12:0] sync1_q;
    reg [12:0] sync2_q;
    wire [12:0] raw_in = {host_line_in, card_line_in, host_clock_in, divider_select_a_in,
                          divider_select_b_in, host_reset_request_in, activation_command_n_in,
                          card_presence_low_in, card_presence_high_in};
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sync1_q <= 13'h1ffe;
            sync2_q <= 13'h1ffe;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end
    wire [2:0] host_s = sync2_q[12:10];
    wire [2:0] card_s = sync2_q[9:7];
    wire hclk_s = sync2_q[6];
    wire [1:0] div_sel_s = {sync2_q[5], sync2_q[4]};
    wire hrst_s = sync2_q[3];
    wire cmd_n_s = sync2_q[2];
    wire pres_raw = ~sync2_q[1] | sync2_q[0];

    // Fault and supply select inputs, synchronised
    reg [3:0] fault1_q;
    reg [3:0] fault2_q;
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            fault1_q <= 4'h0;
            fault2_q <= 4'h0;
        end else begin
            fault1_q <= {card_supply_select_in, supply_overload_in, over_temperature_in, supply_dropout_in};
            fault2_q <= fault1_q;
        end
    end
    wire supply_sel_s = fault2_q[3];
    wire overload_s = fault2_q[2];
    wire fault_any = |fault2_q[2:0];

    // Presence debounce
    reg [18:0] deb_cnt_q;
    reg present_q;
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            deb_cnt_q <= 19'h0_0000;
            present_q <= 1'b0;
        end else if (!pres_raw) begin
            deb_cnt_q <= 19'h0_0000;
            present_q <= 1'b0;
        end else if (!present_q) begin
            if (deb_cnt_q >= DEBOUNCE_CYCLES[18:0] - 19'h0_0001) begin
                present_q <= 1'b1;
            end else begin
                deb_cnt_q <= deb_cnt_q + 19'h0_0001;
            end
        end
    end

    // Host clock divider: counts synchronised host clock rising edges
    reg hclk_d1_q;
    reg [2:0] div_cnt_q;
    wire hclk_rise = hclk_s & ~hclk_d1_q;
    reg divided_clk;
    always @* begin
        case (div_sel_s)
            `DIV_SEL_BY1: divided_clk = hclk_s;
            `DIV_SEL_BY2: divided_clk = div_cnt_q[0];
            `DIV_SEL_BY4: divided_clk = div_cnt_q[1];
            `DIV_SEL_BY8: divided_clk = div_cnt_q[2];
            default: divided_clk = hclk_s;
        endcase
    end
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            hclk_d1_q <= 1'b1;
            div_cnt_q <= 3'h0;
        end else begin
            hclk_d1_q <= hclk_s;
            if (hclk_rise) begin
                div_cnt_q <= div_cnt_q + 3'h1;
            end
        end
    end

    // Activation and deactivation sequencer
    reg [4:0] state_q;
    reg [7:0] step_q;
    reg cmd_n_d1_q;
    wire cmd_fall = cmd_n_d1_q & ~cmd_n_s;
    wire deact_req = fault_any | ~present_q | cmd_n_s;
    wire step_done = (step_q == `DEACT_STEP_CYCLES);
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            step_q <= 8'h00;
            cmd_n_d1_q <= 1'b1;
        end else begin
            cmd_n_d1_q <= cmd_n_s;
            step_q <= (state_q == ST_IDLE || state_q == ST_ACTIVE || step_done) ? 8'h00 : step_q + 8'h01;
            case (state_q)
                ST_IDLE: begin
                    if (cmd_fall && present_q && !fault_any) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (deact_req) begin
                        state_q <= ST_D_RST;
                    end
                end
                ST_D_RST: if (step_done) state_q <= ST_D_CLK;
                ST_D_CLK: if (step_done) state_q <= ST_D_IO;
                ST_D_IO: if (step_done) state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    assign card_active_out = (state_q == ST_ACTIVE);
    wire clk_run = (state_q == ST_ACTIVE) | (state_q == ST_D_RST);
    wire lines_on = clk_run | (state_q == ST_D_CLK);

    // Card outputs
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            card_supply_enable_out <= 1'b0;
            card_supply_5v_out <= 1'b0;
            card_clock_out <= 1'b0;
            card_reset_out <= 1'b0;
            interrupt_n_out <= 1'b1;
        end else begin
            card_supply_enable_out <= (state_q != ST_IDLE);
            card_supply_5v_out <= supply_sel_s;
            card_clock_out <= clk_run ? divided_clk : 1'b0;
            card_reset_out <= card_active_out ? hrst_s : 1'b0;
            interrupt_n_out <= ~(present_q | fault_any | overload_s);
        end
    end

    // Bidirectional relay, open-drain low drive only
    reg [2:0] host_drv_q;
    reg [2:0] card_drv_q;
    // Drive history, masks the synchroniser echo after a release
    reg [2:0] host_d1_q;
    reg [2:0] host_d2_q;
    reg [2:0] card_d1_q;
    reg [2:0] card_d2_q;
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_line
            always @(posedge sys_clk_in) begin
                if (!rst_n_in || !lines_on) begin
                    host_drv_q[i] <= 1'b0;
                    card_drv_q[i] <= 1'b0;
                    host_d1_q[i] <= 1'b0;
                    host_d2_q[i] <= 1'b0;
                    card_d1_q[i] <= 1'b0;
                    card_d2_q[i] <= 1'b0;
                end else begin
                    host_d1_q[i] <= host_drv_q[i];
                    host_d2_q[i] <= host_d1_q[i];
                    card_d1_q[i] <= card_drv_q[i];
                    card_d2_q[i] <= card_d1_q[i];
                    // Owner of a low keeps it; the echo on the far side is ignored
                    host_drv_q[i] <= !card_s[i] && (host_drv_q[i] ||
                        !(card_drv_q[i] || card_d1_q[i] || card_d2_q[i]));
                    card_drv_q[i] <= !host_s[i] && (card_drv_q[i] ||
                        !(host_drv_q[i] || host_d1_q[i] || host_d2_q[i]));
                end
            end
        end
    endgenerate
    assign host_line_out = 3'h0;
    assign card_line_out = 3'h0;
    assign host_line_oe_out = host_drv_q;
    // Card lines held low until supply is up, and from the I/O step on
    assign card_line_oe_out = card_drv_q |
        {3{(state_q == ST_D_IO) | (state_q == ST_IDLE) | !card_supply_enable_out}};
endmodule

// >>> tb/card_model.sv
// Card side model: open-drain card lines with pull-ups
`timescale 1ns/1ps
module card_model (
    input wire [2:0] dut_oe_in,
    input wire [2:0] card_low_in,
    output wire [2:0] line_out
);
    // Pull-up wins unless either party pulls low
    assign line_out = ~(dut_oe_in | card_low_in);
endmodule

// >>> tb/smart_card_interface_control_monitor.sv
// Checker for the smart card interface control block
`timescale 1ns/1ps
module smart_card_interface_control_monitor (
    input wire sys_clk_in, rst_n_in, card_supply_select_in, host_reset_request_in, interrupt_n_out,
    input wire supply_overload_in, over_temperature_in, supply_dropout_in, card_supply_enable_out,
    input wire card_supply_5v_out, card_clock_out, card_reset_out, card_active_out,
    input wire [2:0] host_line_oe_out, card_line_in, card_line_oe_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire fault = supply_overload_in | over_temperature_in | supply_dropout_in;
    wire idle = !card_supply_enable_out;
    sequence s_down;
        ##[0:3] (!card_reset_out && !idle) ##[1:8] (!card_clock_out && !idle) ##[1:12] idle;
    endsequence
    a_int_fault: assert property (fault |-> ##[1:4] !interrupt_n_out) else $error("no fault irq");
    a_fault_deact: assert property (card_active_out && fault |-> ##[1:6] !card_active_out) else $error("no stop");
    a_deact_order: assert property ($fell(card_active_out) |-> s_down) else $error("bad stop order");
    a_supply_sel: assert property (card_active_out |-> card_supply_5v_out == card_supply_select_in)
        else $error("bad supply");
    a_idle_quiet: assert property (idle |-> !card_reset_out && !card_clock_out && card_line_oe_out == 3'h7)
        else $error("idle not quiet");
    a_reset_relay: assert property ((card_active_out && host_reset_request_in)[*4] |-> card_reset_out)
        else $error("reset not relayed");
    a_need_present: assert property ($rose(card_active_out) |-> !interrupt_n_out) else $error("no card");
    a_line_relay: assert property ((card_active_out && !card_line_oe_out[0] && !card_line_in[0])[*4]
        |-> host_line_oe_out[0]) else $error("line not relayed");
endmodule
bind smart_card_interface_control smart_card_interface_control_monitor i_mon (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .card_supply_select_in(card_supply_select_in),
    .host_reset_request_in(host_reset_request_in), .interrupt_n_out(interrupt_n_out),
    .supply_overload_in(supply_overload_in), .over_temperature_in(over_temperature_in),
    .supply_dropout_in(supply_dropout_in), .card_supply_enable_out(card_supply_enable_out),
    .card_supply_5v_out(card_supply_5v_out), .card_clock_out(card_clock_out),
    .card_reset_out(card_reset_out), .card_active_out(card_active_out),
    .host_line_oe_out(host_line_oe_out), .card_line_in(card_line_in), .card_line_oe_out(card_line_oe_out)
);

// >>> tb/smart_card_interface_control_tb.sv
// Self-checking bench for the smart card interface control block
`timescale 1ns/1ps
module smart_card_interface_control_tb;
    localparam DEB = 16;
    reg sys_clk_in = 0, rst_n_in = 0, host_clock_in = 0, divider_select_a_in = 0, divider_select_b_in = 0;
    reg card_supply_select_in = 0, host_reset_request_in = 0, activation_command_n_in = 1;
    reg card_presence_low_in = 1, card_presence_high_in = 0;
    reg supply_overload_in = 0, over_temperature_in = 0, supply_dropout_in = 0, ccp = 0;
    reg [2:0] host_low = 3'h0, card_low = 3'h0;
    reg [3:0] hcnt = 4'h0;
    integer error_cnt = 0, checks_done = 0, seed = 32'ha5c0, rises = 0, r, i, j;
    wire interrupt_n_out, card_supply_enable_out, card_supply_5v_out, card_clock_out, card_reset_out, card_active_out;
    wire [2:0] host_line_out, host_line_oe_out, card_line_out, card_line_oe_out, card_line_in;
    wire [2:0] host_line_in = ~(host_line_oe_out | host_low);
    wire [4:0] st = {interrupt_n_out, card_active_out, card_supply_enable_out, card_supply_5v_out, card_reset_out};
    smart_card_interface_control #(.DEBOUNCE_CYCLES(DEB)) i_dut (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .host_clock_in(host_clock_in),
        .divider_select_a_in(divider_select_a_in), .divider_select_b_in(divider_select_b_in),
        .card_supply_select_in(card_supply_select_in), .host_reset_request_in(host_reset_request_in),
        .activation_command_n_in(activation_command_n_in), .interrupt_n_out(interrupt_n_out),
        .card_presence_low_in(card_presence_low_in), .card_presence_high_in(card_presence_high_in),
        .supply_overload_in(supply_overload_in), .over_temperature_in(over_temperature_in),
        .supply_dropout_in(supply_dropout_in), .card_supply_enable_out(card_supply_enable_out),
        .card_supply_5v_out(card_supply_5v_out), .card_clock_out(card_clock_out),
        .card_reset_out(card_reset_out), .card_active_out(card_active_out),
        .host_line_in(host_line_in), .host_line_out(host_line_out), .host_line_oe_out(host_line_oe_out),
        .card_line_in(card_line_in), .card_line_out(card_line_out), .card_line_oe_out(card_line_oe_out)
    );
    card_model i_card (.dut_oe_in(card_line_oe_out), .card_low_in(card_low), .line_out(card_line_in));
    always #12.5 sys_clk_in = ~sys_clk_in;
    // Host clock at an eighth of the system clock
    always @(posedge sys_clk_in) begin
        hcnt <= hcnt + 4'h1;
        host_clock_in <= hcnt[2];
        ccp <= card_clock_out;
        if (card_clock_out && !ccp) rises <= rises + 1;
    end
    task step(input integer n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task cmp(input string w, input [7:0] e, input [7:0] g);
        checks_done = checks_done + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask
    // Divided edge count may be off by one from start phase
    task cmpn(input integer e, input integer g);
        checks_done = checks_done + 1;
        if (g < e - 1 || g > e + 1) begin
            error_cnt = error_cnt + 1;
            $display("ERROR edges expected %0d seen %0d", e, g);
        end
    endtask
    task conclude;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        step(20000);
        error_cnt = error_cnt + 1;
        conclude;
    end
    initial begin
        step(12);
        rst_n_in <= 1;
        step(3);
        cmp("reset", 8'he2, {card_line_oe_out, host_line_oe_out, interrupt_n_out, card_supply_enable_out});
        cmp("line_out", 8'h00, {host_line_out, card_line_out});
        activation_command_n_in <= 0;
        step(8);
        cmp("refused", 5'h10, st);
        activation_command_n_in <= 1;
        card_presence_low_in <= 0;
        step(DEB - 4);
        cmp("int_n", 1, interrupt_n_out);
        step(10);
        cmp("int_n", 0, interrupt_n_out);
        card_presence_low_in <= 1;
        card_presence_high_in <= 1;
        step(DEB + 10);
        cmp("int_n", 0, interrupt_n_out);
        $display("test presence done");
        for (i = 0; i < 4; i = i + 1) begin
            {divider_select_a_in, divider_select_b_in} <= i[1:0];
            card_supply_select_in <= i[0];
            activation_command_n_in <= 0;
            host_reset_request_in <= 1;
            step(8);
            cmp("active", {3'h3, i[0], 1'b1}, st);
            r = rises;
            step(256);
            cmpn(32 >> i, rises - r);
            j = {$random(seed)} % 3;
            card_low <= 3'h1 << j;
            step(5);
            cmp("host_oe", 3'h1 << j, host_line_oe_out);
            card_low <= 3'h0;
            step(6);
            host_low <= 3'h1 << j;
            step(5);
            cmp("card_oe", 3'h1 << j, card_line_oe_out);
            host_low <= 3'h0;
            activation_command_n_in <= 1;
            step(40);
            cmp("down", 5'h1c, {card_line_oe_out, st[3:2]});
        end
        $display("test divider done");
        for (i = 0; i < 4; i = i + 1) begin
            activation_command_n_in <= 0;
            step(8);
            {supply_dropout_in, over_temperature_in, supply_overload_in} <= 3'h1 << i;
            card_presence_high_in <= (i != 3);
            step(5);
            cmp("int_n", i == 3, interrupt_n_out);
            step(35);
            cmp("fault", 2'h0, st[3:2]);
            {supply_dropout_in, over_temperature_in, supply_overload_in} <= 3'h0;
            card_presence_high_in <= 1;
            activation_command_n_in <= 1;
            step(DEB + 10);
        end
        $display("test faults done");
        conclude;
    end
endmodule
